// >>> hw/stc_pkg.sv
// constants and register map of the synchronised time counter
package stc_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int         ADDR_W      = 8;
    localparam int         IDX_W       = 6;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // register indices, byte address is four times the index
    // ****************************************************************
    localparam logic [IDX_W-1:0] IDX_CTRL       = 6'h00;
    localparam logic [IDX_W-1:0] IDX_STATUS     = 6'h02;
    localparam logic [IDX_W-1:0] IDX_STEP_LO    = 6'h04;
    localparam logic [IDX_W-1:0] IDX_STEP_HI    = 6'h06;
    localparam logic [IDX_W-1:0] IDX_TIME_W0    = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_TIME_W1    = 6'h0e;
    localparam logic [IDX_W-1:0] IDX_TIME_W2    = 6'h10;
    localparam logic [IDX_W-1:0] IDX_TIME_W3    = 6'h12;
    localparam logic [IDX_W-1:0] IDX_MATCH_W0   = 6'h14;
    localparam logic [IDX_W-1:0] IDX_MATCH_W1   = 6'h16;
    localparam logic [IDX_W-1:0] IDX_MATCH_W2   = 6'h18;
    localparam logic [IDX_W-1:0] IDX_MATCH_W3   = 6'h1a;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN     = 6'h34;
    localparam logic [IDX_W-1:0] IDX_STATUS_CLR = 6'h36;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int EVT_W        = 2;
    localparam int EVT_HIT_BIT  = 0;
    localparam int EVT_LOAD_BIT = 1;
    localparam int CTRL_CMP_BIT = 0;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [63:0]      TIME_RST   = 64'h0;
    localparam logic [63:0]      MATCH_RST  = 64'h0;
    localparam logic [31:0]      STEP_RST   = 32'h0;
    localparam logic [31:0]      ACCUM_RST  = 32'h0;
    localparam logic [15:0]      CTRL_RST   = 16'h0;
    localparam logic [EVT_W-1:0] EVT_RST    = 2'h0;

endpackage : stc_pkg

// >>> hw/stc_accum.sv
// frequency scaling accumulator with overflow pulse
module stc_accum
    import stc_pkg::*;
#(
    parameter int ACC_W = 32
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire logic [ACC_W-1:0] step_in,
    output logic                  ovf_out
);

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W:0]   sum_d;
    logic             ovf_q;

    assign sum_d   = {1'b0, acc_q} + {1'b0, step_in};
    assign ovf_out = ovf_q;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_q <= ACCUM_RST[ACC_W-1:0];
            ovf_q <= 1'b0;
        end else begin
            acc_q <= sum_d[ACC_W-1:0];
            ovf_q <= sum_d[ACC_W];
        end
    end

endmodule : stc_accum

// >>> hw/stc_top.sv
// synchronised time counter with first match comparator, axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite register port.
module stc_top
    import stc_pkg::*;
#(
    parameter int TIME_W = 64,
    parameter int ACC_W  = 32
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    output logic                   irq_out
);

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [TIME_W-1:0]  local_time_q;
    logic [TIME_W-17:0] time_latch_q;
    logic [15:0]        stage_q [3];
    logic [15:0]        first_match_q [4];
    logic [TIME_W-1:0]  first_match_value;
    logic [ACC_W-1:0]   step_q;
    logic [15:0]        ctrl_q;
    logic [EVT_W-1:0]   status_q;
    logic [EVT_W-1:0]   irq_en_q;
    logic               irq_q;
    logic               accum_ovf;

    // bus state
    logic               awready_q;
    logic               wready_q;
    logic               aw_hold_q;
    logic               w_hold_q;
    logic [IDX_W-1:0]   wr_idx_q;
    logic [15:0]        wr_data_q;
    logic [1:0]         wr_strb_q;
    logic               bvalid_q;
    logic [1:0]         bresp_q;
    logic               arready_q;
    logic               rvalid_q;
    logic [31:0]        rdata_q;
    logic [1:0]         rresp_q;

    // decode
    logic               do_write;
    logic               wr_mapped;
    logic [IDX_W-1:0]   rd_idx;
    logic               rd_take;
    logic [15:0]        rd_data_d;
    logic               rd_mapped_d;
    logic               match_hit;
    logic [EVT_W-1:0]   evt_set;

    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out  = wready_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = rdata_q;
    assign s_axi_rresp_out   = rresp_q;
    assign irq_out           = irq_q;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  strb);
        logic [15:0] res;
        res[7:0]  = strb[0] ? new_v[7:0]  : old_v[7:0];
        res[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
        return res;
    endfunction : merge16

    // ****************************************************************
    // accumulator
    // ****************************************************************
    stc_accum #(
        .ACC_W    (ACC_W)
    ) u_accum (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .step_in  (step_q),
        .ovf_out  (accum_ovf)
    );

    // ****************************************************************
    // write channel
    // ****************************************************************
    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

    always_comb begin
        case (wr_idx_q)
            IDX_CTRL, IDX_STEP_LO, IDX_STEP_HI,
            IDX_TIME_W0, IDX_TIME_W1, IDX_TIME_W2, IDX_TIME_W3,
            IDX_MATCH_W0, IDX_MATCH_W1, IDX_MATCH_W2, IDX_MATCH_W3,
            IDX_IRQ_EN, IDX_STATUS_CLR: wr_mapped = 1'b1;
            default:                    wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            awready_q <= 1'b1;
            aw_hold_q <= 1'b0;
            wr_idx_q  <= '0;
        end else if (awready_q && s_axi_awvalid_in) begin
            awready_q <= 1'b0;
            aw_hold_q <= 1'b1;
            wr_idx_q  <= s_axi_awaddr_in[ADDR_W-1:2];
        end else if (do_write) begin
            awready_q <= 1'b1;
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wready_q  <= 1'b1;
            w_hold_q  <= 1'b0;
            wr_data_q <= '0;
            wr_strb_q <= '0;
        end else if (wready_q && s_axi_wvalid_in) begin
            wready_q  <= 1'b0;
            w_hold_q  <= 1'b1;
            wr_data_q <= s_axi_wdata_in[15:0];
            wr_strb_q <= s_axi_wstrb_in[1:0];
        end else if (do_write) begin
            wready_q  <= 1'b1;
            w_hold_q  <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    assign rd_take = arready_q && s_axi_arvalid_in;
    assign rd_idx  = s_axi_araddr_in[ADDR_W-1:2];

    always_comb begin
        rd_data_d   = 16'h0;
        rd_mapped_d = 1'b1;
        case (rd_idx)
            IDX_CTRL:       rd_data_d = ctrl_q;
            IDX_STATUS:     rd_data_d = {{(16-EVT_W){1'b0}}, status_q};
            IDX_STEP_LO:    rd_data_d = step_q[15:0];
            IDX_STEP_HI:    rd_data_d = step_q[31:16];
            IDX_TIME_W0:    rd_data_d = local_time_q[15:0];
            IDX_TIME_W1:    rd_data_d = time_latch_q[15:0];
            IDX_TIME_W2:    rd_data_d = time_latch_q[31:16];
            IDX_TIME_W3:    rd_data_d = time_latch_q[47:32];
            IDX_MATCH_W0:   rd_data_d = first_match_q[0];
            IDX_MATCH_W1:   rd_data_d = first_match_q[1];
            IDX_MATCH_W2:   rd_data_d = first_match_q[2];
            IDX_MATCH_W3:   rd_data_d = first_match_q[3];
            IDX_IRQ_EN:     rd_data_d = {{(16-EVT_W){1'b0}}, irq_en_q};
            IDX_STATUS_CLR: rd_data_d = 16'h0;
            default:        rd_mapped_d = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= RESP_OKAY;
        end else if (rd_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {16'h0, rd_data_d};
            rresp_q   <= rd_mapped_d ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready_in) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // upper 48 bits captured when the low word is read
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            time_latch_q <= '0;
        end else if (rd_take && rd_idx == IDX_TIME_W0) begin
            time_latch_q <= local_time_q[TIME_W-1:16];
        end
    end

    // ****************************************************************
    // local time counter
    // ****************************************************************
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 3; i++) begin
                stage_q[i] <= 16'h0;
            end
        end else if (do_write) begin
            for (int i = 0; i < 3; i++) begin
                if (wr_idx_q == IDX_TIME_W0 + IDX_W'(2 * i)) begin
                    stage_q[i] <= merge16(stage_q[i], wr_data_q, wr_strb_q);
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            local_time_q <= TIME_RST;
        end else if (do_write && wr_idx_q == IDX_TIME_W3) begin
            local_time_q <= {merge16(local_time_q[63:48], wr_data_q, wr_strb_q),
                             stage_q[2], stage_q[1], stage_q[0]};
        end else if (accum_ovf) begin
            local_time_q <= local_time_q + 64'h1;
        end
    end

    // ****************************************************************
    // first match value
    // ****************************************************************
    assign first_match_value = {first_match_q[3], first_match_q[2],
                                first_match_q[1], first_match_q[0]};

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 4; i++) begin
                first_match_q[i] <= MATCH_RST[16*i +: 16];
            end
        end else if (do_write) begin
            for (int i = 0; i < 4; i++) begin
                if (wr_idx_q == IDX_MATCH_W0 + IDX_W'(2 * i)) begin
                    first_match_q[i] <= merge16(first_match_q[i], wr_data_q, wr_strb_q);
                end
            end
        end
    end

    // ****************************************************************
    // control and step registers
    // ****************************************************************
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= CTRL_RST;
        end else if (do_write && wr_idx_q == IDX_CTRL) begin
            ctrl_q <= merge16(ctrl_q, wr_data_q, wr_strb_q) & 16'h0001;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            step_q <= STEP_RST;
        end else if (do_write && wr_idx_q == IDX_STEP_LO) begin
            step_q[15:0] <= merge16(step_q[15:0], wr_data_q, wr_strb_q);
        end else if (do_write && wr_idx_q == IDX_STEP_HI) begin
            step_q[31:16] <= merge16(step_q[31:16], wr_data_q, wr_strb_q);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_en_q <= EVT_RST;
        end else if (do_write && wr_idx_q == IDX_IRQ_EN && wr_strb_q[0]) begin
            irq_en_q <= wr_data_q[EVT_W-1:0];
        end
    end

    // ****************************************************************
    // events and interrupt
    // ****************************************************************
    assign match_hit = ctrl_q[CTRL_CMP_BIT]
                       && (local_time_q == first_match_value);

    always_comb begin
        evt_set               = '0;
        evt_set[EVT_HIT_BIT]  = match_hit;
        evt_set[EVT_LOAD_BIT] = do_write && wr_idx_q == IDX_TIME_W3;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_q <= EVT_RST;
        end else if (do_write && wr_idx_q == IDX_STATUS_CLR && wr_strb_q[0]) begin
            status_q <= (status_q & ~wr_data_q[EVT_W-1:0]) | evt_set;
        end else begin
            status_q <= status_q | evt_set;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & irq_en_q);
        end
    end

endmodule : stc_top

// >>> bench/stc_assertions.sv
// bus protocol checker for the time counter block
module stc_assertions
    import stc_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    property p_b_hold;
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_r_hi;
        s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0;
    endproperty
    a_r_hi: assert property (p_r_hi) else $error("upper read bits set");
    property p_aw_take;
        s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out;
    endproperty
    a_aw_take: assert property (p_aw_take) else $error("awready stayed high");
    property p_w_ans;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            |=> ##1 s_axi_bvalid_out;
    endproperty
    a_w_ans: assert property (p_w_ans) else $error("write answer late");
    property p_r_ans;
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    property p_b_done;
        s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out ##0 s_axi_awready_out;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write not closed");
    property p_ar_block;
        s_axi_rvalid_out |-> !s_axi_arready_out;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("arready during read");
endmodule : stc_assertions

bind stc_top stc_assertions chk (.*);

// >>> bench/stc_host.sv
// host processor model issuing axi4-lite register accesses
module stc_host
    import stc_pkg::*;
(
    input wire logic              mclk_in,
    output logic [ADDR_W-1:0]     s_axi_awaddr_in,
    output logic                  s_axi_awvalid_in,
    input wire logic              s_axi_awready_out,
    output logic [31:0]           s_axi_wdata_in,
    output logic [3:0]            s_axi_wstrb_in,
    output logic                  s_axi_wvalid_in,
    input wire logic              s_axi_wready_out,
    input wire logic [1:0]        s_axi_bresp_out,
    input wire logic              s_axi_bvalid_out,
    output logic                  s_axi_bready_in,
    output logic [ADDR_W-1:0]     s_axi_araddr_in,
    output logic                  s_axi_arvalid_in,
    input wire logic              s_axi_arready_out,
    input wire logic [31:0]       s_axi_rdata_out,
    input wire logic [1:0]        s_axi_rresp_out,
    input wire logic              s_axi_rvalid_out,
    output logic                  s_axi_rready_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {s_axi_awaddr_in, s_axi_awvalid_in, s_axi_wdata_in, s_axi_wvalid_in} = '0;
        {s_axi_bready_in, s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
        s_axi_wstrb_in = 4'h3;
    end
    // released payload shows inverted bits
    task automatic wr(input logic [5:0] i, input logic [15:0] d, output logic [1:0] r);
        s_axi_awaddr_in <= {i, 2'h0};
        s_axi_wdata_in <= {16'h0, d};
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                s_axi_awvalid_in <= 1'b0;
                s_axi_awaddr_in <= ~s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                s_axi_wvalid_in <= 1'b0;
                s_axi_wdata_in <= ~s_axi_wdata_in;
            end
        end while (s_axi_bvalid_out !== 1'b1);
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
        // idle edge, next call never reassigns bready in this step
        @(posedge mclk_in);
    endtask : wr
    task automatic rd(input logic [5:0] i, output logic [15:0] d, output logic [1:0] r);
        s_axi_araddr_in <= {i, 2'h0};
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_arvalid_in <= 1'b0;
                s_axi_araddr_in <= ~s_axi_araddr_in;
            end
        end while (s_axi_rvalid_out !== 1'b1);
        d = s_axi_rdata_out[15:0];
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
        // idle edge, next call never reassigns rready in this step
        @(posedge mclk_in);
    endtask : rd
endmodule : stc_host

// >>> bench/tb_sync_time_counter_target_match.sv
// self-checking bench of the time counter block
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_sync_time_counter_target_match
    import stc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in, rst_n_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
    logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, irq_out;
    logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
    logic [ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0]       s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0]        s_axi_wstrb_in;
    logic [1:0]        s_axi_bresp_out, s_axi_rresp_out;
    int                fails = 0;
    int                total_checks = 0;
    logic [5:0]        tw[4] = '{IDX_TIME_W0, IDX_TIME_W1, IDX_TIME_W2, IDX_TIME_W3};
    logic [5:0]        mw[4] = '{IDX_MATCH_W0, IDX_MATCH_W1, IDX_MATCH_W2, IDX_MATCH_W3};
    localparam logic [63:0] T = 64'h0123_4567_89ab_cdef;

    stc_top uut (.*);
    stc_host host (.*);

    initial mclk_in = 1'b0;
    always #50 mclk_in = ~mclk_in;

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic w(input logic [5:0] i, input logic [15:0] d);
        logic [1:0] r;
        host.wr(i, d, r);
        `CHK(r, RESP_OKAY)
    endtask : w
    task automatic rc(input logic [5:0] i, input logic [15:0] e);
        logic [15:0] d;
        logic [1:0]  r;
        host.rd(i, d, r);
        `CHK({r, d}, {RESP_OKAY, e})
    endtask : rc
    task automatic hit(input logic e);
        logic [15:0] d;
        logic [1:0]  r;
        host.rd(IDX_STATUS, d, r);
        `CHK(d[EVT_HIT_BIT], e)
        `CHK(irq_out, e)
    endtask : hit
    task automatic ld(input logic [63:0] t);
        for (int k = 0; k < 4; k++) w(tw[k], t[16*k+:16]);
    endtask : ld

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        for (int k = 0; k < 4; k++) begin
            rc(tw[k], 16'h0);
            rc(mw[k], 16'h0);
        end
        rc(IDX_STATUS, 16'h0);
    endtask : t_reset
    task automatic t_match_rw;
        logic [15:0] d;
        logic [1:0]  r;
        w(mw[3], 16'hd3c2);
        w(mw[1], 16'hb1a0);
        w(mw[0], 16'ha0b1);
        w(mw[2], 16'hc2d3);
        rc(mw[2], 16'hc2d3);
        rc(mw[0], 16'ha0b1);
        rc(mw[3], 16'hd3c2);
        rc(mw[1], 16'hb1a0);
        host.wr(6'h3f, 16'h5a5a, r);
        `CHK(r, RESP_SLVERR)
        host.rd(6'h3f, d, r);
        `CHK({r, d}, {RESP_SLVERR, 16'h0})
    endtask : t_match_rw
    task automatic t_load;
        for (int k = 0; k < 3; k++) w(tw[k], {4{k[3:0] + 4'h1}});
        rc(tw[0], 16'h0);
        w(tw[3], 16'h4444);
        for (int k = 0; k < 4; k++) rc(tw[k], {4{k[3:0] + 4'h1}});
        repeat (20) @(posedge mclk_in);
        rc(tw[0], 16'h1111);
    endtask : t_load
    task automatic t_latch;
        logic [15:0] d;
        logic [1:0]  r;
        ld(64'h0000_0000_0000_fff8);
        rc(tw[0], 16'hfff8);
        w(IDX_STEP_HI, 16'h8000);
        repeat (40) @(posedge mclk_in);
        w(IDX_STEP_HI, 16'h0);
        rc(tw[1], 16'h0);
        host.rd(tw[0], d, r);
        rc(tw[1], 16'h0001);
        rc(tw[3], 16'h0);
    endtask : t_latch
    task automatic t_match_irq;
        w(IDX_IRQ_EN, 16'h1);
        ld(T);
        rc(IDX_STATUS, 16'h0002);
        w(IDX_STATUS_CLR, 16'h3);
        w(IDX_CTRL, 16'h0);
        for (int k = 0; k < 4; k++) w(mw[k], T[16*k+:16]);
        hit(1'b0);
        w(IDX_CTRL, 16'h1);
        hit(1'b1);
        w(IDX_IRQ_EN, 16'h0);
        rc(IDX_STATUS, 16'h1);
        `CHK(irq_out, 1'b0)
        w(IDX_CTRL, 16'h0);
        w(IDX_STATUS_CLR, 16'h1);
        w(mw[0], T[15:0] + 16'h3);
        w(IDX_CTRL, 16'h1);
        w(IDX_IRQ_EN, 16'h1);
        hit(1'b0);
        w(IDX_STEP_HI, 16'h8000);
        repeat (30) @(posedge mclk_in);
        w(IDX_STEP_HI, 16'h0);
        hit(1'b1);
        w(IDX_STATUS_CLR, 16'h1);
        hit(1'b0);
    endtask : t_match_irq

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        rst_n_in = 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        t_reset();
        t_match_rw();
        t_load();
        t_latch();
        t_match_irq();
        end_sim();
    end
    initial begin
        #2000000;
        fails++;
        end_sim();
    end
endmodule : tb_sync_time_counter_target_match
